// file: src/ldbl_pkg.sv
// Functional notes
// - While pci_output_enable is high, drive the PCI AD bus; else release it.
// - Falling memory_read_latch_enable captures the memory data bus; latch then holds.
// - Latch enable low in a PCI master read loads host or memory data.
// - CPU read of PCI: AD captured into CPU read buffer on PCI clock rise.
// - PCI master write: AD captured into PCI-to-memory buffer on PCI clock rise.
// - Active-low parity error output flags bad parity on captured memory read data.
// - Host source select: 00 float, 01 all ones, 10 PCI data, 11 memory data.
// - CPU-to-memory push high stores host data each clock and advances the pointer, unless the buffer is full.
// - Prelatch enable copies the CPU-to-PCI output entry into the prelatch for AD.
package ldbl_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] LDBL_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LDBL_STATUS_ADDR = 8'h04;
  localparam logic [7:0] LDBL_MASK_ADDR   = 8'h08;
  localparam logic [7:0] LDBL_LEVEL_ADDR  = 8'h0C;
  localparam logic [7:0] LDBL_MLAT_LO_ADDR = 8'h10;
  localparam logic [7:0] LDBL_MLAT_HI_ADDR = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int LDBL_CTRL_CHK_EN_BIT = 0;
  localparam int LDBL_CTRL_ODD_BIT    = 1;
  localparam int LDBL_EV_PARITY_BIT   = 0;
  localparam int LDBL_EV_PCI_OVF_BIT  = 1;
  localparam int LDBL_EV_MEM_OVF_BIT  = 2;
  localparam int LDBL_EV_WIDTH        = 3;
  localparam int LDBL_LVL_PCI_CNT_LSB = 0;
  localparam int LDBL_LVL_MEM_CNT_LSB = 8;
  localparam int LDBL_LVL_HOLD_BIT    = 16;
  localparam int LDBL_LVL_PERR_BIT    = 17;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] LDBL_CTRL_RESET = 2'h1;
  localparam logic [2:0] LDBL_MASK_RESET = 3'h0;

  // ==========================================================================
  // Host source select codes and PCI cycle kinds
  localparam logic [1:0] LDBL_HSEL_FLOAT = 2'h0;
  localparam logic [1:0] LDBL_HSEL_ONES  = 2'h1;
  localparam logic [1:0] LDBL_HSEL_PCI   = 2'h2;
  localparam logic [1:0] LDBL_HSEL_MEM   = 2'h3;
  localparam logic [1:0] LDBL_KIND_IDLE      = 2'h0;
  localparam logic [1:0] LDBL_KIND_CPU_RD    = 2'h1;
  localparam logic [1:0] LDBL_KIND_PCI_MS_RD = 2'h2;
  localparam logic [1:0] LDBL_KIND_PCI_MS_WR = 2'h3;

endpackage

// file: src/ldbl_parity.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Per-byte parity, one bit per byte lane
module ldbl_parity
  import ldbl_pkg::*;
#(
  parameter int BYTES = 8
) (
  input  wire logic [8*BYTES-1:0] data,
  input  wire logic               odd,
  output logic      [BYTES-1:0]   parity
);

  // Lane n covers bits 8n..8n+7
  always_comb begin
    for (int n = 0; n < BYTES; n++) begin
      parity[n] = (^data[8*n +: 8]) ^ odd;
    end
  end

endmodule
`default_nettype wire

// file: src/ldbl_latch_control.sv
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module ldbl_latch_control
  import ldbl_pkg::*;
#(
  parameter int PCI_DEPTH = 4,
  parameter int MEM_DEPTH = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  input  wire logic [63:0] host_data_bus_in,
  output logic      [63:0] host_data_bus_out,
  output logic             host_data_bus_oe_n,
  input  wire logic [63:0] memory_data_bus_in,
  output logic      [63:0] memory_data_bus_out,
  output logic             memory_data_bus_oe_n,
  input  wire logic [7:0]  memory_parity_bus_in,
  output logic      [7:0]  memory_parity_bus_out,
  output logic             memory_parity_bus_oe_n,
  input  wire logic [31:0] pci_ad_in,
  output logic      [31:0] pci_ad_out,
  output logic             pci_ad_oe_n,
  input  wire logic        pci_clock,
  input  wire logic        pci_output_enable,
  input  wire logic        hold_grant,
  input  wire logic        memory_read_latch_enable,
  input  wire logic        pci_side_latch_enable_n,
  input  wire logic [1:0]  pci_cycle_kind,
  input  wire logic        pci_read_from_memory,
  input  wire logic        high_dword_select,
  input  wire logic [1:0]  host_bus_source_select,
  input  wire logic        cpu_pci_buffer_push,
  input  wire logic        cpu_pci_buffer_pop,
  input  wire logic        cpu_memory_buffer_push,
  input  wire logic        cpu_memory_buffer_pop,
  input  wire logic        prelatch_enable,
  input  wire logic        memory_drive_enable,
  output logic             parity_error_n
);

  localparam int PW = $clog2(PCI_DEPTH);
  localparam int MW = $clog2(MEM_DEPTH);

  generate
    if (PCI_DEPTH < 2 || PCI_DEPTH > 128 || (1 << PW) != PCI_DEPTH) begin : g_bad_pci
      $error("PCI_DEPTH must be a power of two from 2 to 128");
    end
    if (MEM_DEPTH < 2 || MEM_DEPTH > 128 || (1 << MW) != MEM_DEPTH) begin : g_bad_mem
      $error("MEM_DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  // ==========================================================================
  // Posted write buffers and latches
  logic [31:0] cpu_to_pci_write_buffer [PCI_DEPTH];
  logic [63:0] cpu_to_memory_write_buffer [MEM_DEPTH];
  logic [PW-1:0] pci_wr_q, pci_rd_q;
  logic [MW-1:0] mem_wr_q, mem_rd_q;
  logic [PW:0]   pci_cnt_q;
  logic [MW:0]   mem_cnt_q;
  logic [63:0] mem_latch_q, pci_read_buffer_q, cpu_read_pci_q, pci_to_memory_write_buffer_q;
  logic [31:0] prelatch_q;
  logic        push_pci_q, pop_pci_q, pci_clk_q, memory_read_latch_enable_q, perr_q;
  logic [1:0]  ctrl_q;
  logic [2:0]  status_q, mask_q;

  // Edge detect of strobes; inputs are synchronous so one stage suffices
  logic pci_push_rise, pci_pop_rise, pci_clk_rise, memory_read_latch_enable_fall;
  assign pci_push_rise = cpu_pci_buffer_push & ~push_pci_q;
  assign pci_pop_rise  = cpu_pci_buffer_pop & ~pop_pci_q;
  assign pci_clk_rise  = pci_clock & ~pci_clk_q;
  assign memory_read_latch_enable_fall     = memory_read_latch_enable_q & ~memory_read_latch_enable;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      push_pci_q <= 1'b0;
      pop_pci_q  <= 1'b0;
      pci_clk_q  <= 1'b0;
      memory_read_latch_enable_q     <= 1'b0;
    end else begin
      push_pci_q <= cpu_pci_buffer_push;
      pop_pci_q  <= cpu_pci_buffer_pop;
      pci_clk_q  <= pci_clock;
      memory_read_latch_enable_q     <= memory_read_latch_enable;
    end
  end

  // Push while full is dropped and reported, so the oldest entries survive
  logic pci_full, mem_full, pci_push_ok, pci_pop_ok, mem_push_ok, mem_pop_ok;
  assign pci_full    = pci_cnt_q == (PW+1)'(PCI_DEPTH);
  assign mem_full    = mem_cnt_q == (MW+1)'(MEM_DEPTH);
  assign pci_push_ok = pci_push_rise & ~pci_full;
  assign pci_pop_ok  = pci_pop_rise & (pci_cnt_q != '0);
  assign mem_push_ok = cpu_memory_buffer_push & ~mem_full;
  assign mem_pop_ok  = cpu_memory_buffer_pop & (mem_cnt_q != '0);

  // CPU-to-PCI buffer pointers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pci_wr_q  <= '0;
      pci_rd_q  <= '0;
      pci_cnt_q <= '0;
    end else begin
      if (pci_push_ok) begin
        cpu_to_pci_write_buffer[pci_wr_q] <= host_data_bus_in[31:0];
        pci_wr_q <= pci_wr_q + 1'b1;
      end
      if (pci_pop_ok) begin
        pci_rd_q <= pci_rd_q + 1'b1;
      end
      pci_cnt_q <= pci_cnt_q + (PW+1)'(pci_push_ok) - (PW+1)'(pci_pop_ok);
    end
  end

  // CPU-to-memory buffer pointers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_wr_q  <= '0;
      mem_rd_q  <= '0;
      mem_cnt_q <= '0;
    end else begin
      if (mem_push_ok) begin
        cpu_to_memory_write_buffer[mem_wr_q] <= host_data_bus_in;
        mem_wr_q <= mem_wr_q + 1'b1;
      end
      if (mem_pop_ok) begin
        mem_rd_q <= mem_rd_q + 1'b1;
      end
      mem_cnt_q <= mem_cnt_q + (MW+1)'(mem_push_ok) - (MW+1)'(mem_pop_ok);
    end
  end

  // ==========================================================================
  // Read latches and PCI-side buffers
  logic [7:0] chk_parity, gen_parity;
  logic [63:0] md_out_d;

  ldbl_parity #(.BYTES(8)) u_check (
    .data   (memory_data_bus_in),
    .odd    (ctrl_q[LDBL_CTRL_ODD_BIT]),
    .parity (chk_parity)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_latch_q <= '0;
      perr_q      <= 1'b0;
    end else if (memory_read_latch_enable_fall) begin
      mem_latch_q <= memory_data_bus_in;
      perr_q      <= ctrl_q[LDBL_CTRL_CHK_EN_BIT] & (chk_parity != memory_parity_bus_in);
    end
  end

  // PCI read buffer loads on the ref clock; only the AD side waits for PCI edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pci_read_buffer_q <= '0;
    end else if (pci_cycle_kind == LDBL_KIND_PCI_MS_RD && !pci_side_latch_enable_n) begin
      pci_read_buffer_q <= pci_read_from_memory ? memory_data_bus_in : host_data_bus_in;
    end
  end

  // High dword select picks the half being assembled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cpu_read_pci_q               <= '0;
      pci_to_memory_write_buffer_q <= '0;
    end else if (pci_clk_rise && !pci_side_latch_enable_n) begin
      if (pci_cycle_kind == LDBL_KIND_CPU_RD) begin
        cpu_read_pci_q[32*high_dword_select +: 32] <= pci_ad_in;
      end
      if (pci_cycle_kind == LDBL_KIND_PCI_MS_WR) begin
        pci_to_memory_write_buffer_q[32*high_dword_select +: 32] <= pci_ad_in;
      end
    end
  end

  // Prelatch holds the current output entry of the CPU-to-PCI buffer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prelatch_q <= '0;
    end else if (prelatch_enable) begin
      prelatch_q <= cpu_to_pci_write_buffer[pci_rd_q];
    end
  end

  // ==========================================================================
  // Bus drivers, all registered so the pins change one clock after control
  assign md_out_d = (pci_cycle_kind == LDBL_KIND_PCI_MS_WR) ? pci_to_memory_write_buffer_q
                                                            : cpu_to_memory_write_buffer[mem_rd_q];

  ldbl_parity #(.BYTES(8)) u_gen (
    .data   (md_out_d),
    .odd    (ctrl_q[LDBL_CTRL_ODD_BIT]),
    .parity (gen_parity)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pci_ad_oe_n            <= 1'b1;
      host_data_bus_oe_n     <= 1'b1;
      memory_data_bus_oe_n   <= 1'b1;
      memory_parity_bus_oe_n <= 1'b1;
      pci_ad_out             <= '0;
      host_data_bus_out      <= '0;
      memory_data_bus_out    <= '0;
      memory_parity_bus_out  <= '0;
    end else begin
      pci_ad_oe_n <= ~pci_output_enable;
      pci_ad_out  <= (pci_cycle_kind == LDBL_KIND_PCI_MS_RD)
                     ? pci_read_buffer_q[32*high_dword_select +: 32] : prelatch_q;
      host_data_bus_oe_n <= (host_bus_source_select == LDBL_HSEL_FLOAT);
      unique case (host_bus_source_select)
        LDBL_HSEL_FLOAT: host_data_bus_out <= '0;
        LDBL_HSEL_ONES:  host_data_bus_out <= '1;
        LDBL_HSEL_PCI:   host_data_bus_out <= (pci_cycle_kind == LDBL_KIND_PCI_MS_WR)
                                              ? pci_to_memory_write_buffer_q : cpu_read_pci_q;
        LDBL_HSEL_MEM:   host_data_bus_out <= mem_latch_q;
      endcase
      // Parity lane bus moves with the data bus, never alone
      memory_data_bus_oe_n   <= ~memory_drive_enable;
      memory_parity_bus_oe_n <= ~memory_drive_enable;
      memory_data_bus_out    <= md_out_d;
      memory_parity_bus_out  <= gen_parity;
    end
  end

  // Parity error pin follows the last latch capture; a capture taken with checking off reads inactive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      parity_error_n <= 1'b1;
    end else begin
      parity_error_n <= ~perr_q;
    end
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic       ph_valid_q, ph_write_q;
  logic [7:0] ph_addr_q;
  logic       addr_phase;
  logic [2:0] events, w1c;
  logic [31:0] rd_d;
  assign addr_phase = hsel & hready & htrans[1];

  always_comb begin
    unique case (haddr[7:0])
      LDBL_CTRL_ADDR:    rd_d = {30'h0, ctrl_q};
      LDBL_STATUS_ADDR:  rd_d = {29'h0, status_q};
      LDBL_MASK_ADDR:    rd_d = {29'h0, mask_q};
      LDBL_LEVEL_ADDR:   rd_d = {14'h0, ~parity_error_n, hold_grant,
                                 8'((mem_cnt_q)), 8'((pci_cnt_q))};
      LDBL_MLAT_LO_ADDR: rd_d = mem_latch_q[31:0];
      LDBL_MLAT_HI_ADDR: rd_d = mem_latch_q[63:32];
      default:           rd_d = 32'h0;
    endcase
    if (haddr[31:8] != 24'h0) begin
      rd_d = 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= '0;
      hrdata     <= '0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      ph_valid_q <= addr_phase && haddr[31:8] == 24'h0;
      ph_write_q <= hwrite;
      ph_addr_q  <= haddr[7:0];
      hrdata     <= (addr_phase && !hwrite) ? rd_d : 32'h0;
    end
  end

  // Control and mask writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= LDBL_CTRL_RESET;
      mask_q <= LDBL_MASK_RESET;
    end else if (ph_valid_q && ph_write_q) begin
      if (ph_addr_q == LDBL_CTRL_ADDR) ctrl_q <= hwdata[1:0];
      if (ph_addr_q == LDBL_MASK_ADDR) mask_q <= hwdata[2:0];
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign events[LDBL_EV_PARITY_BIT]  = memory_read_latch_enable_fall & ctrl_q[LDBL_CTRL_CHK_EN_BIT]
                                       & (chk_parity != memory_parity_bus_in);
  assign events[LDBL_EV_PCI_OVF_BIT] = pci_push_rise & pci_full;
  assign events[LDBL_EV_MEM_OVF_BIT] = cpu_memory_buffer_push & mem_full;
  assign w1c = (ph_valid_q && ph_write_q && ph_addr_q == LDBL_STATUS_ADDR) ? hwdata[2:0] : 3'h0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_q <= '0;
      irq      <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c) | events;
      irq      <= |(((status_q & ~w1c) | events) & mask_q);
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_ad_drive_on:    assert property (pci_output_enable |=> !pci_ad_oe_n)
    else $error("AD bus not driven after enable");
  a_ad_drive_off:   assert property (!pci_output_enable |=> pci_ad_oe_n)
    else $error("AD bus driven without enable");
  a_mem_latch_cap:  assert property (memory_read_latch_enable_fall |=> mem_latch_q == $past(memory_data_bus_in))
    else $error("memory latch missed capture");
  a_mem_latch_hold: assert property (!memory_read_latch_enable && !memory_read_latch_enable_fall |=> $stable(mem_latch_q))
    else $error("memory latch changed while held");
  a_pci_read_buffer_load:      assert property (pci_cycle_kind == LDBL_KIND_PCI_MS_RD && !pci_side_latch_enable_n
                      && pci_read_from_memory |=> pci_read_buffer_q == $past(memory_data_bus_in))
    else $error("PCI read buffer not loaded");
  a_cpu_rd_store:   assert property (pci_clk_rise && !pci_side_latch_enable_n && !high_dword_select
                      && pci_cycle_kind == LDBL_KIND_CPU_RD |=> cpu_read_pci_q[31:0] == $past(pci_ad_in))
    else $error("CPU read buffer not stored");
  a_pci_wr_store:   assert property (pci_clk_rise && !pci_side_latch_enable_n && high_dword_select
                      && pci_cycle_kind == LDBL_KIND_PCI_MS_WR
                      |=> pci_to_memory_write_buffer_q[63:32] == $past(pci_ad_in))
    else $error("PCI write buffer not stored");
  a_parity_err:     assert property (events[LDBL_EV_PARITY_BIT] |=> ##1 !parity_error_n)
    else $error("parity error not flagged");
  a_host_ones:      assert property (host_bus_source_select == LDBL_HSEL_ONES
                      |=> !host_data_bus_oe_n && host_data_bus_out == 64'hFFFFFFFFFFFFFFFF)
    else $error("host bus not all ones");
  a_host_float:     assert property (host_bus_source_select == LDBL_HSEL_FLOAT |=> host_data_bus_oe_n)
    else $error("host bus not released");
  a_pci_push:       assert property (pci_push_ok && !pci_pop_ok |=> pci_cnt_q == $past(pci_cnt_q) + 1'b1)
    else $error("CPU-to-PCI push lost");
  a_mem_push:       assert property (mem_push_ok && !mem_pop_ok |=> mem_wr_q == $past(mem_wr_q) + 1'b1)
    else $error("CPU-to-memory push lost");
  a_prelatch_copy:  assert property (prelatch_enable |=> prelatch_q == $past(cpu_to_pci_write_buffer[pci_rd_q]))
    else $error("prelatch not loaded");
  a_parity_lane:    assert property (!memory_parity_bus_oe_n |-> memory_data_bus_oe_n == 1'b0
                      && memory_parity_bus_out[7] == ((^memory_data_bus_out[63:56])
                      ^ $past(ctrl_q[LDBL_CTRL_ODD_BIT])))
    else $error("parity lane mismatch");
  a_reset_release:  assert property ($past(reset) |-> pci_ad_oe_n && host_data_bus_oe_n
                      && memory_data_bus_oe_n && pci_cnt_q == '0 && mem_cnt_q == '0)
    else $error("buses or buffers not cleared by reset");

  c_pci_full:    cover property (pci_full ##1 pci_pop_ok);
  c_parity_irq:  cover property (events[LDBL_EV_PARITY_BIT] ##[1:3] irq);
  c_cpu_rd_pair: cover property (pci_clk_rise && pci_cycle_kind == LDBL_KIND_CPU_RD ##[1:8]
                   host_bus_source_select == LDBL_HSEL_PCI);

endmodule
`default_nettype wire

// file: tb/ldbl_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Far side of the buffer: memory, PCI and host wires
module ldbl_far_model (
  input  wire logic        ref_clk,
  input  wire logic        pci_run,
  input  wire logic [63:0] mem_val,
  input  wire logic [7:0]  par_val,
  input  wire logic [31:0] pci_val,
  input  wire logic [63:0] host_val,
  input  wire logic [63:0] mem_o,
  input  wire logic        mem_oe_n,
  input  wire logic [7:0]  par_o,
  input  wire logic        par_oe_n,
  input  wire logic [31:0] pci_o,
  input  wire logic        pci_oe_n,
  input  wire logic [63:0] host_o,
  input  wire logic        host_oe_n,
  output logic      [63:0] mem_i,
  output logic      [7:0]  par_i,
  output logic      [31:0] pci_i,
  output logic      [63:0] host_i,
  output logic             pci_clock
);
  // Wire level: the device wins while it drives, else our value
  assign mem_i  = mem_oe_n ? mem_val : mem_o;
  assign par_i  = par_oe_n ? par_val : par_o;
  assign pci_i  = pci_oe_n ? pci_val : pci_o;
  assign host_i = host_oe_n ? host_val : host_o;
  // PCI clock stands still outside frames
  initial pci_clock = 1'b0;
  always @(posedge ref_clk) begin
    pci_clock <= pci_run ? ~pci_clock : 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/local_data_buffer_latch_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module local_data_buffer_latch_control_tb
  import ldbl_pkg::*;
;
  // ============================================================
  // Stimulus and observed signals
  logic        ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, pci_i, pci_o;
  logic [1:0]  htrans = 2'h0, cyc_kind = 2'h0, src_sel = 2'h0;
  logic        hreadyout, hresp, irq, perr_n, pci_clock;
  logic [63:0] host_i, host_o, mem_i, mem_o, mem_val = '0, host_val = '0;
  logic [7:0]  par_i, par_o, par_val = '0;
  logic [31:0] pci_val = '0;
  logic        host_oe_n, mem_oe_n, par_oe_n, pci_oe_n, pci_run = 1'b0;
  logic        pci_oe_en = 1'b0, hold_g = 1'b0, mem_le = 1'b0, pci_le_n = 1'b1;
  logic        rd_mem = 1'b0, hi_dw = 1'b0, cp_push = 1'b0, cp_pop = 1'b0;
  logic        cm_push = 1'b0, cm_pop = 1'b0, pre_en = 1'b0, mem_drv = 1'b0;
  logic [63:0] d1 = 64'h0123_4567_89AB_CDEF;
  int          fails = 0, n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  ldbl_latch_control i_ldbl_latch_control (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .host_data_bus_in(host_i), .host_data_bus_out(host_o), .host_data_bus_oe_n(host_oe_n),
    .memory_data_bus_in(mem_i), .memory_data_bus_out(mem_o), .memory_data_bus_oe_n(mem_oe_n),
    .memory_parity_bus_in(par_i), .memory_parity_bus_out(par_o),
    .memory_parity_bus_oe_n(par_oe_n), .pci_ad_in(pci_i), .pci_ad_out(pci_o),
    .pci_ad_oe_n(pci_oe_n), .pci_clock(pci_clock), .pci_output_enable(pci_oe_en),
    .hold_grant(hold_g), .memory_read_latch_enable(mem_le),
    .pci_side_latch_enable_n(pci_le_n), .pci_cycle_kind(cyc_kind),
    .pci_read_from_memory(rd_mem), .high_dword_select(hi_dw),
    .host_bus_source_select(src_sel), .cpu_pci_buffer_push(cp_push),
    .cpu_pci_buffer_pop(cp_pop), .cpu_memory_buffer_push(cm_push),
    .cpu_memory_buffer_pop(cm_pop), .prelatch_enable(pre_en),
    .memory_drive_enable(mem_drv), .parity_error_n(perr_n)
  );

  ldbl_far_model i_ldbl_far_model (
    .ref_clk(ref_clk), .pci_run(pci_run), .mem_val(mem_val), .par_val(par_val),
    .pci_val(pci_val), .host_val(host_val), .mem_o(mem_o), .mem_oe_n(mem_oe_n),
    .par_o(par_o), .par_oe_n(par_oe_n), .pci_o(pci_o), .pci_oe_n(pci_oe_n),
    .host_o(host_o), .host_oe_n(host_oe_n), .mem_i(mem_i), .par_i(par_i),
    .pci_i(pci_i), .host_i(host_i), .pci_clock(pci_clock)
  );

  // ============================================================
  // Shared helpers
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Bounded wait for hready at a rising edge
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k == 50) fails++;
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk({32'h0, r}, {32'h0, e});
  endtask
  // Even parity per byte lane, the reset setting
  function automatic logic [7:0] par8(input logic [63:0] d);
    for (int i = 0; i < 8; i++) par8[i] = ^d[8*i+:8];
  endfunction
  task oes(input logic [3:0] e);
    chk({60'h0, host_oe_n, mem_oe_n, par_oe_n, pci_oe_n}, {60'h0, e});
  endtask
  task fin(input string s);
    $display("test %s done", s);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ============================================================
  // Test sequence
  initial begin
    tick(10);
    reset <= 1'b0;
    rdc(LDBL_CTRL_ADDR, 32'h1);
    rdc(LDBL_LEVEL_ADDR, 32'h0);
    rdc(8'h40, 32'h0);
    oes(4'hF);
    src_sel <= LDBL_HSEL_ONES;
    tick(3);
    chk(host_o, {64{1'b1}});
    oes(4'h7);
    src_sel <= LDBL_HSEL_FLOAT;
    tick(3);
    oes(4'hF);
    fin("reset_and_select");
    // Capture on falling enable, then hold while the bus moves on
    mem_val <= d1;
    par_val <= par8(d1);
    mem_le <= 1'b1;
    tick(2);
    mem_le <= 1'b0;
    tick(2);
    mem_val <= ~d1;
    tick(2);
    rdc(LDBL_MLAT_LO_ADDR, d1[31:0]);
    rdc(LDBL_MLAT_HI_ADDR, d1[63:32]);
    chk({63'h0, perr_n}, 64'h1);
    src_sel <= LDBL_HSEL_MEM;
    tick(3);
    chk(host_o, d1);
    src_sel <= LDBL_HSEL_FLOAT;
    // One bad lane: fault flagged, interrupt only once unmasked
    par_val <= par8(~d1) ^ 8'h04;
    mem_le <= 1'b1;
    tick(2);
    mem_le <= 1'b0;
    tick(3);
    chk({63'h0, perr_n}, 64'h0);
    rdc(LDBL_STATUS_ADDR, 32'h1);
    chk({63'h0, irq}, 64'h0);
    wr(LDBL_MASK_ADDR, 32'h1);
    tick(2);
    chk({63'h0, irq}, 64'h1);
    par_val <= par8(~d1);
    mem_le <= 1'b1;
    tick(2);
    mem_le <= 1'b0;
    tick(3);
    chk({63'h0, perr_n}, 64'h1);
    wr(LDBL_STATUS_ADDR, 32'h1);
    tick(2);
    chk({63'h0, irq}, 64'h0);
    fin("memory_latch_parity");
    // Five pushes into four entries: last one refused
    hold_g <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      host_val <= {32'h0, 32'hC0DE_0000 + i};
      cp_push <= 1'b1;
      tick(2);
      cp_push <= 0;
      tick(2);
    end
    rdc(LDBL_LEVEL_ADDR, 32'h1_0004);
    rdc(LDBL_STATUS_ADDR, 32'h2);
    pre_en <= 1'b1;
    tick(1);
    pre_en <= 1'b0;
    pci_oe_en <= 1'b1;
    tick(3);
    chk({32'h0, pci_o}, 64'hC0DE_0000);
    oes(4'hE);
    pci_oe_en <= 1'b0;
    tick(3);
    oes(4'hF);
    cp_pop <= 1'b1;
    tick(2);
    cp_pop <= 1'b0;
    cm_push <= 1'b1;
    pre_en <= 1'b1;
    tick(3);
    cm_push <= 1'b0;
    pre_en <= 1'b0;
    tick(2);
    chk({32'h0, pci_o}, 64'hC0DE_0001);
    rdc(LDBL_LEVEL_ADDR, 32'h1_0303);
    cm_pop <= 1'b1;
    tick(2);
    cm_pop <= 1'b0;
    tick(1);
    rdc(LDBL_LEVEL_ADDR, 32'h1_0103);
    fin("posted_buffers");
    mem_drv <= 1'b1;
    tick(3);
    oes(4'h9);
    chk(mem_o, 64'h0000_0000_C0DE_0004);
    chk({56'h0, par_o}, {56'h0, par8(mem_o)});
    mem_drv <= 1'b0;
    // PCI capture for a CPU read and a master write
    for (int k = 0; k < 2; k++) begin
      cyc_kind <= (k == 1) ? LDBL_KIND_PCI_MS_WR : LDBL_KIND_CPU_RD;
      hi_dw <= (k == 1);
      pci_val <= 32'h5A5A_0F00 + k;
      pci_le_n <= 1'b0;
      pci_run <= 1'b1;
      tick(4);
      pci_run <= 1'b0;
      pci_le_n <= 1'b1;
      src_sel <= LDBL_HSEL_PCI;
      tick(3);
      chk({32'h0, host_o[32*k +: 32]}, {32'h0, 32'h5A5A_0F00 + k});
      src_sel <= LDBL_HSEL_FLOAT;
      cyc_kind <= LDBL_KIND_IDLE;
      hi_dw <= 1'b0;
      tick(1);
    end
    // PCI master read of memory: buffer loads, then both halves go out on AD
    cyc_kind <= LDBL_KIND_PCI_MS_RD;
    rd_mem <= 1'b1;
    pci_le_n <= 1'b0;
    pci_oe_en <= 1'b1;
    tick(2);
    pci_le_n <= 1'b1;
    tick(2);
    chk({32'h0, pci_o}, {32'h0, ~d1[31:0]});
    hi_dw <= 1'b1;
    tick(2);
    chk({32'h0, pci_o}, {32'h0, ~d1[63:32]});
    oes(4'hE);
    cyc_kind <= LDBL_KIND_IDLE;
    rd_mem <= 1'b0;
    hi_dw <= 1'b0;
    pci_oe_en <= 1'b0;
    tick(2);
    fin("pci_capture");
    // Reset in mid-run empties the buffers
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    rdc(LDBL_LEVEL_ADDR, 32'h1_0000);
    oes(4'hF);
    fin("second_reset");
    wrap_up();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
